/* File: dv/dcc_ana_model.sv */
module dcc_ana_model
    import dcc_pkg::*;
(
    // Comparator controls from the block.
    input  wire dcc_ana_t         a_in,
    input  wire dcc_ana_t         b_in,
    // Pin levels in millivolts.
    input  wire logic [3:0][11:0] pin_mv_in,
    // Raw comparator outputs.
    output logic                  a_raw_out,
    output logic                  b_raw_out
);
    timeunit 1ns;
    timeprecision 1ns;

    // An unpowered or disconnected comparator rests low.
    function automatic logic cmp(input dcc_ana_t c,
                                 input logic [3:0][11:0] p);
        int r;
        r = (c.neg_ref == 2'h1) ? 1200 : (c.neg_ref == 2'h2) ? 1400 : 1300;
        return (c.enable === 1'b1) && (c.connect === 1'b1)
            && (p[c.pos_chan] > r);
    endfunction

    assign a_raw_out = cmp(a_in, pin_mv_in);
    assign b_raw_out = cmp(b_in, pin_mv_in);
endmodule

/* File: dv/dcc_top_assertions.sv */
module dcc_top_assertions
    import dcc_pkg::*;
(
    // Watched ports.
    input wire logic     core_clk_in,
    input wire logic     resetn_in,
    input wire logic     wb_cyc_in,
    input wire logic     wb_stb_in,
    input wire logic     wb_we_in,
    input wire logic     wb_ack_out,
    input wire logic     power_down_in,
    input wire logic     cmp_a_raw_in,
    input wire dcc_ana_t cmp_a_ana_out,
    input wire dcc_ana_t cmp_b_ana_out,
    input wire logic     cmp_a_level_out,
    input wire logic     cmp_b_level_out,
    input wire logic     irq_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);

    wire logic req = wb_cyc_in & wb_stb_in;
    wire logic wr  = req & wb_we_in;

    a_ack_follows: assert property (req && !wb_ack_out |=> wb_ack_out)
        else $error("ack missing");
    a_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack too long");
    a_pd_enable: assert property (power_down_in [*2] |->
        !cmp_a_ana_out.enable && !cmp_b_ana_out.enable)
        else $error("enable in power down");
    a_pd_level: assert property (power_down_in [*3] |->
        !cmp_a_level_out && !cmp_b_level_out)
        else $error("level in power down");
    a_off_level_a: assert property (!cmp_a_ana_out.enable [*3] |->
        !cmp_a_level_out)
        else $error("disabled a not low");
    a_off_level_b: assert property (!cmp_b_ana_out.enable [*3] |->
        !cmp_b_level_out)
        else $error("disabled b not low");
    a_sync_delay: assert property ($rose(cmp_a_level_out) |->
        $past(cmp_a_raw_in, 2) || $past(cmp_a_raw_in, 3))
        else $error("level not synchronised");
    a_irq_sticky: assert property ($fell(irq_out) |->
        $past(wr, 1) || $past(wr, 2) || $past(wr, 3) || $past(wr, 4))
        else $error("irq fell without write");

    c_irq: cover property ($rose(irq_out));
    c_pd: cover property (power_down_in ##1 !power_down_in);
    c_wr: cover property (wr && wb_ack_out);
endmodule

bind dcc_top dcc_top_assertions u_chk (
    .core_clk_in, .resetn_in, .wb_cyc_in, .wb_stb_in, .wb_we_in,
    .wb_ack_out, .power_down_in, .cmp_a_raw_in, .cmp_a_ana_out,
    .cmp_b_ana_out, .cmp_a_level_out, .cmp_b_level_out, .irq_out
);

/* File: dv/test_dual_comparator_control.sv */
module test_dual_comparator_control
    import dcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [11:0] LO  = 12'h3e8;
    localparam logic [11:0] MID = 12'h546;
    logic             clk = 1'b0;
    logic             rstn = 1'b0;
    logic             cyc = 1'b0;
    logic             stb = 1'b0;
    logic             we = 1'b0;
    logic             pd = 1'b0;
    logic [2:0]       tmr = 3'h0;
    logic [7:0]       adr = 8'h00;
    logic [31:0]      wd = 32'h0;
    logic [31:0]      dout, rdat;
    logic             ack, raw_a, raw_b, lv_a, lv_b, irq;
    dcc_ana_t         ana_a, ana_b;
    logic [3:0][11:0] pv = {4{LO}};
    int               n_mismatch = 0;
    int               checks = 0;
    int               ncyc = 0;

    dcc_top dut_u (
        .core_clk_in(clk), .resetn_in(rstn), .wb_cyc_in(cyc),
        .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
        .wb_sel_in(4'h1), .wb_dat_in(wd), .wb_dat_out(dout),
        .wb_ack_out(ack), .power_down_in(pd), .timer0_ovf_in(tmr[0]),
        .timer1_ovf_in(tmr[1]), .timer2_ovf_in(tmr[2]),
        .cmp_a_raw_in(raw_a), .cmp_b_raw_in(raw_b),
        .cmp_a_ana_out(ana_a), .cmp_b_ana_out(ana_b),
        .cmp_a_level_out(lv_a), .cmp_b_level_out(lv_b), .irq_out(irq));
    dcc_ana_model mdl_u (.a_in(ana_a), .b_in(ana_b), .pin_mv_in(pv),
        .a_raw_out(raw_a), .b_raw_out(raw_b));

    always #20 clk = ~clk;

    task automatic report_and_stop;
        if (n_mismatch == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        ncyc <= ncyc + 1;
        if (ncyc == 8000) begin
            n_mismatch++;
            report_and_stop;
        end
    end

    task automatic chk(input string n, input logic [31:0] g, e);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wd <= {24'h0, d};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rdat = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rc(input string n, input logic [7:0] a,
                      input logic [31:0] e);
        bus(1'b0, a, 8'h00);
        chk(n, rdat, e);
    endtask

    task automatic pause;
        repeat (8) @(posedge clk);
    endtask

    task automatic tick(input logic [2:0] m);
        @(posedge clk);
        tmr <= m;
        @(posedge clk);
        tmr <= 3'h0;
        pause;
    endtask

    task automatic s_regs;
        for (int i = 0; i < 6; i++) begin
            rc("reset_val", {i[5:0], 2'h0}, 32'h0);
        end
        bus(1'b1, 8'h14, 8'hff);
        rc("unmapped", 8'h14, 32'h0);
    endtask

    task automatic s_modes;
        logic [3:0] g;
        logic [3:0] e [6];
        e = '{4'hd, 4'h7, 4'h5, 4'h0, 4'h1, 4'h4};
        for (int m = 0; m < 6; m++) begin
            bus(1'b1, 8'h00, {5'h05, m[2:0]});
            pause;
            bus(1'b1, 8'h0c, 8'h01);
            pause;
            bus(1'b0, 8'h0c, 8'h00);
            g[3] = rdat[0];
            pv[0] <= MID;
            pause;
            bus(1'b0, 8'h0c, 8'h00);
            g[2] = rdat[0];
            bus(1'b1, 8'h0c, 8'h01);
            pause;
            bus(1'b0, 8'h0c, 8'h00);
            g[1] = rdat[0];
            pv[0] <= LO;
            pause;
            bus(1'b0, 8'h0c, 8'h00);
            g[0] = rdat[0];
            chk("mode", {28'h0, g}, {28'h0, e[m]});
        end
    endtask

    task automatic s_irq;
        pv[1] <= MID;
        bus(1'b1, 8'h04, 8'h49);
        bus(1'b1, 8'h04, 8'h69);
        repeat (250) @(posedge clk);
        bus(1'b1, 8'h0c, 8'h02);
        bus(1'b1, 8'h10, 8'h02);
        pause;
        chk("irq", {31'h0, irq}, 32'h1);
        rc("stat", 8'h0c, 32'h0a);
        bus(1'b1, 8'h10, 8'h00);
        pause;
        chk("irq_mask", {31'h0, irq}, 32'h0);
        pv[1] <= LO;
        pause;
        rc("sticky", 8'h0c, 32'h02);
        bus(1'b1, 8'h0c, 8'h02);
        bus(1'b1, 8'h10, 8'h02);
        pause;
        rc("cleared", 8'h0c, 32'h0);
        chk("irq_off", {31'h0, irq}, 32'h0);
        bus(1'b1, 8'h10, 8'h00);
    endtask

    task automatic s_timer;
        logic [2:0] m;
        bus(1'b1, 8'h00, 8'h29);
        for (int t = 1; t < 4; t++) begin
            m = 3'h1 << (t - 1);
            bus(1'b1, 8'h08, t[7:0]);
            tick(m);
            bus(1'b1, 8'h0c, 8'h01);
            pv[0] <= MID;
            tick(~m);
            rc("smp_wait", 8'h0c, 32'h04);
            tick(m);
            rc("smp_hit", 8'h0c, 32'h05);
            pv[0] <= LO;
        end
        bus(1'b1, 8'h08, 8'h00);
    endtask

    task automatic s_pd;
        pv[0] <= MID;
        pause;
        chk("lvl_a", {31'h0, lv_a}, 32'h1);
        pd <= 1'b1;
        pause;
        bus(1'b1, 8'h0c, 8'h01);
        pause;
        chk("pd_ana", {30'h0, ana_a.enable, ana_b.enable}, 32'h0);
        rc("pd_stat", 8'h0c, 32'h0);
        pd <= 1'b0;
        pause;
        rc("wake", 8'h0c, 32'h05);
        bus(1'b1, 8'h00, 8'h21);
        pause;
        bus(1'b1, 8'h0c, 8'h01);
        pause;
        rc("off_stat", 8'h0c, 32'h0);
        chk("off_ana", {30'h0, ana_a.enable, ana_b.enable}, 32'h1);
    endtask

    task automatic s_chan;
        logic [3:0][11:0] v;
        logic [1:0]       pc;
        pc = 2'h1;
        for (int c = 0; c < 4; c++) begin
            for (int r = 0; r < 3; r++) begin
                v = {4{LO}};
                v[c] = MID;
                pv <= v;
                bus(1'b1, 8'h04, {pc, 6'h09});
                bus(1'b1, 8'h08, {r[1:0], 6'h00});
                bus(1'b1, 8'h04, {c[1:0], 6'h09});
                bus(1'b1, 8'h04, {c[1:0], 6'h29});
                bus(1'b1, 8'h0c, 8'h02);
                pc = c[1:0];
                pause;
                chk("b_ana", {26'h0, ana_b},
                    {26'h0, 2'h3, c[1:0], r[1:0]});
                chk("b_lvl", {31'h0, lv_b}, {31'h0, r < 2});
            end
        end
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        s_regs;
        s_modes;
        s_irq;
        s_timer;
        s_pd;
        s_chan;
        report_and_stop;
    end
endmodule

/* File: src/dcc_channel.sv */
module dcc_channel
    import dcc_pkg::*;
(
    // Clock and reset.
    input  wire logic      core_clk_in,
    input  wire logic      resetn_in,
    // Comparator side.
    input  wire logic      raw_in,
    input  wire logic      active_in,
    input  wire logic      tick_in,
    input  wire dcc_mode_t mode_in,
    // Results.
    output logic           level_out,
    output logic           event_out
);

    logic sync1_q;
    logic sync2_q;
    logic level_q;
    logic samp_q;
    logic prev_q;
    logic samp_v_q;
    wire  logic level_d;
    wire  logic hit;

    // A disabled comparator reads low.
    assign level_d = active_in & sync2_q;

    assign hit = (mode_in == DCC_MODE_LOW)    ? ~samp_q :
                 (mode_in == DCC_MODE_HIGH)   ?  samp_q :
                 (mode_in == DCC_MODE_TOGGLE) ? (samp_q ^ prev_q) :
                 (mode_in == DCC_MODE_FALL)   ? (~samp_q & prev_q) :
                 (mode_in == DCC_MODE_RISE)   ? (samp_q & ~prev_q) :
                 1'b0;

    assign event_out = samp_v_q & active_in & hit;
    assign level_out = level_q;

    // The raw output is high when the positive input is above the negative.
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
        end
    end

    // Consecutive samples are taken only at the chosen sample points.
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            level_q  <= 1'b0;
            samp_q   <= 1'b0;
            prev_q   <= 1'b0;
            samp_v_q <= 1'b0;
        end else begin
            level_q  <= level_d;
            samp_v_q <= tick_in;
            if (tick_in) begin
                samp_q <= level_d;
                prev_q <= samp_q;
            end
        end
    end

endmodule

/* File: src/dcc_map.svh */
// Function
// - Output high when positive input exceeds negative.
// - Independent enable bit 3 per comparator.
// - Flag sets when sampled output meets mode.
// - Flags pollable, interrupt capable, software cleared only.
// - Both comparators share one interrupt output.
// - Sample every clock or on timer overflow.
// - Comparators keep running and flagging during idle.
// - Power-down forces both comparators disabled.
// - Channel select routes one of four pins.
// - Reference select picks nominal or plus/minus level.
// - Disabled comparator output low, no new flags.
`ifndef DCC_MAP_SVH
`define DCC_MAP_SVH

// Register byte offsets.
`define DCC_OFS_CSR_A     8'h00
`define DCC_OFS_CSR_B     8'h04
`define DCC_OFS_REF_CTRL  8'h08
`define DCC_OFS_IRQ_STAT  8'h0c
`define DCC_OFS_IRQ_MASK  8'h10

// Control and status register fields.
`define DCC_CSR_MODE_LSB  0
`define DCC_CSR_EN_BIT    3
`define DCC_CSR_FLAG_BIT  4
`define DCC_CSR_CONN_BIT  5
`define DCC_CSR_CHAN_LSB  6

// Reference control fields.
`define DCC_REF_SMPA_LSB  0
`define DCC_REF_SMPB_LSB  2
`define DCC_REF_RFA_LSB   4
`define DCC_REF_RFB_LSB   6

// Interrupt status layout: flags in bits 1-0, live outputs in bits 3-2.
`define DCC_STAT_LVL_LSB  2

// Reset values.
`define DCC_CSR_RST       7'h00
`define DCC_REF_RST       8'h00
`define DCC_MASK_RST      2'h0

`endif

/* File: src/dcc_pkg.sv */
package dcc_pkg;

    // Interrupt condition encodings.
    typedef enum logic [2:0] {
        DCC_MODE_LOW    = 3'h0,
        DCC_MODE_HIGH   = 3'h1,
        DCC_MODE_TOGGLE = 3'h2,
        DCC_MODE_NONE   = 3'h3,
        DCC_MODE_FALL   = 3'h4,
        DCC_MODE_RISE   = 3'h5,
        DCC_MODE_RSV6   = 3'h6,
        DCC_MODE_RSV7   = 3'h7
    } dcc_mode_t;

    // Sample point selection.
    typedef enum logic [1:0] {
        DCC_SMP_CLOCK  = 2'h0,
        DCC_SMP_TIMER0 = 2'h1,
        DCC_SMP_TIMER1 = 2'h2,
        DCC_SMP_TIMER2 = 2'h3
    } dcc_smp_t;

    // Software view of one comparator control register.
    typedef struct packed {
        logic [1:0] chan;
        logic       conn;
        logic       en;
        dcc_mode_t  mode;
    } dcc_csr_t;

    // Controls sent to one analog comparator.
    typedef struct packed {
        logic       enable;
        logic       connect;
        logic [1:0] pos_chan;
        logic [1:0] neg_ref;
    } dcc_ana_t;

endpackage

/* File: src/dcc_top.sv */
`include "dcc_map.svh"

module dcc_top
    import dcc_pkg::*;
(
    // Clock and reset.
    input  wire logic        core_clk_in,
    input  wire logic        resetn_in,
    // Wishbone classic slave.
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [7:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic      [31:0] wb_dat_out,
    output logic             wb_ack_out,
    // System events.
    input  wire logic        power_down_in,
    input  wire logic        timer0_ovf_in,
    input  wire logic        timer1_ovf_in,
    input  wire logic        timer2_ovf_in,
    // Analog comparators.
    input  wire logic        cmp_a_raw_in,
    input  wire logic        cmp_b_raw_in,
    output dcc_ana_t         cmp_a_ana_out,
    output dcc_ana_t         cmp_b_ana_out,
    output logic             cmp_a_level_out,
    output logic             cmp_b_level_out,
    // Shared interrupt.
    output logic             irq_out
);

    dcc_csr_t    csr_q [2];
    logic [7:0]  ref_q;
    logic [1:0]  flag_q;
    logic [1:0]  mask_q;
    logic        ack_q;
    logic [31:0] rdat_q;
    logic        irq_q;
    dcc_ana_t    ana_a_q;
    dcc_ana_t    ana_b_q;

    wire logic       req;
    wire logic       wr_go;
    wire logic       lane0;
    wire logic       hit_csr_a;
    wire logic       hit_csr_b;
    wire logic       hit_ref;
    wire logic       hit_stat;
    wire logic       hit_mask;
    wire logic [1:0] active;
    wire logic [1:0] tick;
    wire logic [1:0] level;
    wire logic [1:0] event_p;
    wire logic [1:0] flag_d;
    wire logic [1:0] clr;
    wire logic [7:0] rd_byte;

    // Picks the sample point for one comparator.
    function automatic logic sel_tick(input logic [1:0] sel,
                                      input logic t0,
                                      input logic t1,
                                      input logic t2);
        logic r;
        r = 1'b1;
        unique case (dcc_smp_t'(sel))
            DCC_SMP_CLOCK:  r = 1'b1;
            DCC_SMP_TIMER0: r = t0;
            DCC_SMP_TIMER1: r = t1;
            DCC_SMP_TIMER2: r = t2;
        endcase
        return r;
    endfunction

    // Packs a control register for read back.
    function automatic logic [7:0] csr_byte(input dcc_csr_t c,
                                            input logic f);
        return {c.chan, c.conn, f, c.en, c.mode};
    endfunction

    // Bus decode.
    assign req       = wb_cyc_in & wb_stb_in;
    assign wr_go     = req & wb_we_in & ack_q;
    assign lane0     = wb_sel_in[0];
    assign hit_csr_a = (wb_adr_in == `DCC_OFS_CSR_A);
    assign hit_csr_b = (wb_adr_in == `DCC_OFS_CSR_B);
    assign hit_ref   = (wb_adr_in == `DCC_OFS_REF_CTRL);
    assign hit_stat  = (wb_adr_in == `DCC_OFS_IRQ_STAT);
    assign hit_mask  = (wb_adr_in == `DCC_OFS_IRQ_MASK);

    assign rd_byte = hit_csr_a ? csr_byte(csr_q[0], flag_q[0]) :
                     hit_csr_b ? csr_byte(csr_q[1], flag_q[1]) :
                     hit_ref   ? ref_q :
                     hit_stat  ? {4'h0, level, flag_q} :
                     hit_mask  ? {6'h00, mask_q} :
                     8'h00;

    // Enables are independent and overridden by power-down only.
    assign active[0] = csr_q[0].en & ~power_down_in;
    assign active[1] = csr_q[1].en & ~power_down_in;

    // Idle has no input here, so enabled comparators keep working.
    assign tick[0] = sel_tick(ref_q[`DCC_REF_SMPA_LSB +: 2], timer0_ovf_in,
                              timer1_ovf_in, timer2_ovf_in);
    assign tick[1] = sel_tick(ref_q[`DCC_REF_SMPB_LSB +: 2], timer0_ovf_in,
                              timer1_ovf_in, timer2_ovf_in);

    // Flags clear only by a written one, and a new event wins.
    assign clr    = (wr_go & hit_stat & lane0) ? wb_dat_in[1:0] : 2'h0;
    assign flag_d = (flag_q & ~clr) | event_p;

    dcc_channel u_chan_a (
        .core_clk_in (core_clk_in),
        .resetn_in   (resetn_in),
        .raw_in      (cmp_a_raw_in),
        .active_in   (active[0]),
        .tick_in     (tick[0]),
        .mode_in     (csr_q[0].mode),
        .level_out   (level[0]),
        .event_out   (event_p[0])
    );

    dcc_channel u_chan_b (
        .core_clk_in (core_clk_in),
        .resetn_in   (resetn_in),
        .raw_in      (cmp_b_raw_in),
        .active_in   (active[1]),
        .tick_in     (tick[1]),
        .mode_in     (csr_q[1].mode),
        .level_out   (level[1]),
        .event_out   (event_p[1])
    );

    // Bus answer one cycle after the request, write at the ack edge.
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q  <= req & ~ack_q;
            rdat_q <= {24'h00_0000, rd_byte};
        end
    end

    // Register writes.
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            csr_q[0] <= dcc_csr_t'(`DCC_CSR_RST);
            csr_q[1] <= dcc_csr_t'(`DCC_CSR_RST);
            ref_q    <= `DCC_REF_RST;
            mask_q   <= `DCC_MASK_RST;
        end else if (wr_go && lane0) begin
            if (hit_csr_a) begin
                csr_q[0] <= {wb_dat_in[7:5], wb_dat_in[3:0]};
            end
            if (hit_csr_b) begin
                csr_q[1] <= {wb_dat_in[7:5], wb_dat_in[3:0]};
            end
            if (hit_ref) begin
                ref_q <= wb_dat_in[7:0];
            end
            if (hit_mask) begin
                mask_q <= wb_dat_in[1:0];
            end
        end
    end

    // Flags, shared interrupt and analog controls.
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            flag_q  <= 2'h0;
            irq_q   <= 1'b0;
            ana_a_q <= '0;
            ana_b_q <= '0;
        end else begin
            flag_q <= flag_d;
            irq_q  <= |(flag_d & mask_q);
            ana_a_q.enable   <= active[0];
            ana_a_q.connect  <= csr_q[0].conn;
            ana_a_q.pos_chan <= csr_q[0].chan;
            ana_a_q.neg_ref  <= ref_q[`DCC_REF_RFA_LSB +: 2];
            ana_b_q.enable   <= active[1];
            ana_b_q.connect  <= csr_q[1].conn;
            ana_b_q.pos_chan <= csr_q[1].chan;
            ana_b_q.neg_ref  <= ref_q[`DCC_REF_RFB_LSB +: 2];
        end
    end

    assign wb_ack_out      = ack_q;
    assign wb_dat_out      = rdat_q;
    assign irq_out         = irq_q;
    assign cmp_a_ana_out   = ana_a_q;
    assign cmp_b_ana_out   = ana_b_q;
    assign cmp_a_level_out = level[0];
    assign cmp_b_level_out = level[1];

endmodule
